// [core/clock_mode_and_timer_pins.sv]
// Machine clock, clock-mode straps, oscillator pins and timer outputs
`default_nettype none
module clock_mode_and_timer_pins (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic OUTPUT_FLOAT_B,
  input wire logic CLOCK_MODE_SEL_A,
  input wire logic CLOCK_MODE_SEL_B,
  input wire logic CLOCK_MODE_SEL_C,
  input wire logic SW_MODE_WE,
  input wire logic [clk_pins_pkg::MODE_W-1:0] SW_MODE_DATA,
  output logic [clk_pins_pkg::MODE_W-1:0] CLOCK_MODE,
  input wire logic OSC_IN_EXT_CLOCK,
  input wire logic INT_OSC_EN,
  output logic EXT_CLOCK_LEVEL,
  output logic CRYSTAL_DRIVE_OUT,
  output logic MACHINE_CLOCK_OUT,
  output logic MACHINE_CLOCK_OUT_OE,
  input wire logic TIMER0_UNDERFLOW,
  input wire logic TIMER1_UNDERFLOW,
  input wire logic HOST_PORT_EN,
  input wire logic HOST_INTERRUPT_REQ,
  output logic TIMER0_PULSE_OUT,
  output logic TIMER0_PULSE_OUT_OE,
  output logic TIMER1_PULSE_OUT,
  output logic TIMER1_PULSE_OUT_OE
);
  mode_if mif ();

  logic rst_meta_r;
  logic rst_done_r;
  logic [clk_pins_pkg::MODE_W-1:0] strap_meta_r;
  logic [clk_pins_pkg::MODE_W-1:0] strap_sync_r;
  logic osc_meta_r;
  logic osc_sync_r;
  logic ext_clock_r;
  logic crystal_r;
  logic [clk_pins_pkg::PHASE_W-1:0] phase_r;
  logic [clk_pins_pkg::PHASE_W-1:0] phase_nxt;
  logic mclk_out_r;
  logic cycle_start;
  logic [clk_pins_pkg::TIMER_N-1:0] underflow;
  logic [clk_pins_pkg::TIMER_N-1:0] pend_r;
  logic [clk_pins_pkg::TIMER_N-1:0] pulse_r;

  // Stretches reset two edges past release so straps can be sampled
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_meta_r <= 1'b0;
      rst_done_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_done_r <= rst_meta_r;
    end
  end

  // No reset here: these must keep sampling while reset is held
  always_ff @(posedge MCLK)
  begin
    strap_meta_r <= {CLOCK_MODE_SEL_C, CLOCK_MODE_SEL_B, CLOCK_MODE_SEL_A};
    strap_sync_r <= strap_meta_r;
  end

  assign mif.in_reset = !rst_done_r;
  assign mif.sw_we = SW_MODE_WE;
  assign mif.sw_data = SW_MODE_DATA;
  assign mif.pins_sync = strap_sync_r;

  mode_latch u_mode_latch (
    .MCLK (MCLK),
    .RST_B (RST_B),
    .mif (mif.latch)
  );

  assign CLOCK_MODE = mif.mode;

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
    end
    else
    begin
      osc_meta_r <= OSC_IN_EXT_CLOCK;
      osc_sync_r <= osc_meta_r;
    end
  end

  // Only a level view of the external clock; the PLL itself is elsewhere
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      ext_clock_r <= 1'b0;
    else
      ext_clock_r <= INT_OSC_EN ? 1'b0 : osc_sync_r;
  end

  // Crystal drive idles low when the oscillator is bypassed
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      crystal_r <= 1'b0;
    else
      crystal_r <= INT_OSC_EN & ~osc_sync_r;
  end

  assign EXT_CLOCK_LEVEL = ext_clock_r;
  assign CRYSTAL_DRIVE_OUT = crystal_r;

  assign cycle_start = (phase_r == clk_pins_pkg::MC_LAST);
  assign phase_nxt = cycle_start ? '0 : phase_r + 1'b1;

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      phase_r <= clk_pins_pkg::PHASE_RST;
    else
      phase_r <= phase_nxt;
  end

  // High for the first half, so every machine cycle opens on a rise
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      mclk_out_r <= 1'b1;
    else
      mclk_out_r <= (phase_nxt < clk_pins_pkg::MC_HALF);
  end

  assign underflow = {TIMER1_UNDERFLOW, TIMER0_UNDERFLOW};

  // Pending flag holds an underflow until the next cycle start; an
  // underflow on the start edge itself goes straight to the pin.
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      pend_r <= '0;
    else if (cycle_start)
      pend_r <= '0;
    else
      pend_r <= pend_r | underflow;
  end

  // Pulse registers change only at cycle starts, so each pulse is one full cycle
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      pulse_r <= '0;
    else if (cycle_start)
      pulse_r <= pend_r | underflow;
  end

  // Float override is combinational so it works with the clock stopped
  assign MACHINE_CLOCK_OUT = mclk_out_r;
  assign MACHINE_CLOCK_OUT_OE = OUTPUT_FLOAT_B;
  assign TIMER0_PULSE_OUT = pulse_r[0];
  assign TIMER0_PULSE_OUT_OE = OUTPUT_FLOAT_B;
  assign TIMER1_PULSE_OUT = HOST_PORT_EN ? HOST_INTERRUPT_REQ
                                         : pulse_r[1];
  assign TIMER1_PULSE_OUT_OE = OUTPUT_FLOAT_B;

  mclk_rise_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    $rose(mclk_out_r) |-> (phase_r == '0))
  else $error("machine clock rose away from cycle start");

  mclk_period_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    $rose(mclk_out_r) |-> ##2 $rose(mclk_out_r))
  else $error("machine clock period wrong");

  mclk_float_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    !OUTPUT_FLOAT_B |-> !MACHINE_CLOCK_OUT_OE)
  else $error("machine clock driven while float asserted");

  timer_float_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    !OUTPUT_FLOAT_B |-> !(TIMER0_PULSE_OUT_OE | TIMER1_PULSE_OUT_OE))
  else $error("timer output driven while float asserted");

  float_release_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    OUTPUT_FLOAT_B |-> (MACHINE_CLOCK_OUT_OE && TIMER0_PULSE_OUT_OE))
  else $error("outputs floated without float request");

  timer0_pulse_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    $rose(pulse_r[0]) |-> $rose(mclk_out_r) ##1 pulse_r[0]
      ##1 (pulse_r[0] == $past(pend_r[0] | underflow[0])))
  else $error("timer 0 pulse not one machine cycle");

  timer1_pulse_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    (cycle_start && TIMER1_UNDERFLOW) |=> pulse_r[1] [*2])
  else $error("timer 1 pulse missing or short");

  timer0_catch_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    TIMER0_UNDERFLOW |-> ##[1:2] (pulse_r[0] && $rose(mclk_out_r)))
  else $error("timer 0 underflow lost");

  shared_pin_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    !HOST_PORT_EN |-> (TIMER1_PULSE_OUT == pulse_r[1]))
  else $error("timer 1 pulse not on shared pin");

  crystal_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    !INT_OSC_EN |=> !CRYSTAL_DRIVE_OUT)
  else $error("crystal drive active while oscillator bypassed");

  ext_clock_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    !INT_OSC_EN |=> (ext_clock_r == $past(osc_sync_r)))
  else $error("external clock level not followed");
endmodule : clock_mode_and_timer_pins
`default_nettype wire

// [core/clk_pins_pkg.sv]
// Constants shared by the clock-mode and timer-pin logic
`default_nettype none
package clk_pins_pkg;
  localparam int unsigned MODE_W = 3;
  localparam logic [MODE_W-1:0] MODE_RST = 3'h7;
  localparam real MCLK_PERIOD_NS = 20.0;
  localparam real MACHINE_CYCLE_NS = 40.0;
  localparam int unsigned MC_DIV_INT =
    (int'(MACHINE_CYCLE_NS / MCLK_PERIOD_NS) < 2) ? 2 :
    int'(MACHINE_CYCLE_NS / MCLK_PERIOD_NS);
  localparam int unsigned PHASE_W = $clog2(MC_DIV_INT);
  localparam logic [PHASE_W-1:0] MC_LAST = PHASE_W'(MC_DIV_INT - 1);
  localparam logic [PHASE_W-1:0] MC_HALF = PHASE_W'(MC_DIV_INT / 2);
  localparam logic [PHASE_W-1:0] PHASE_RST = '0;
  localparam int unsigned TIMER_N = 2;
  localparam int unsigned SYNC_STAGES = 2;
endpackage : clk_pins_pkg
`default_nettype wire

// [core/mode_if.sv]
// Carrier between the pin core and the clock-mode latch
`default_nettype none
interface mode_if;
  logic in_reset;
  logic sw_we;
  logic [clk_pins_pkg::MODE_W-1:0] sw_data;
  logic [clk_pins_pkg::MODE_W-1:0] pins_sync;
  logic [clk_pins_pkg::MODE_W-1:0] mode;
  modport latch (
    input in_reset,
    input sw_we,
    input sw_data,
    input pins_sync,
    output mode
  );
  modport core (
    output in_reset,
    output sw_we,
    output sw_data,
    output pins_sync,
    input mode
  );
endinterface : mode_if
`default_nettype wire

// [core/mode_latch.sv]
// Clock mode register: strap capture during reset, software after
`default_nettype none
module mode_latch (
  input wire logic MCLK,
  input wire logic RST_B,
  mode_if.latch mif
);
  logic [clk_pins_pkg::MODE_W-1:0] mode_r;

  // Straps can only be seen once the async reset lets go, so the
  // capture runs through the stretched synchronous reset window.
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      mode_r <= clk_pins_pkg::MODE_RST;
    else if (mif.in_reset)
      mode_r <= mif.pins_sync;
    else if (mif.sw_we)
      mode_r <= mif.sw_data;
  end

  assign mif.mode = mode_r;

  strap_capture_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    // Release edge is skipped: the register was still held in reset there
    (RST_B && mif.in_reset) |=> (mode_r == $past(mif.pins_sync)))
  else $error("mode not loaded from straps during reset");

  strap_ignored_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    (!mif.in_reset && !mif.sw_we) |=> $stable(mode_r))
  else $error("mode changed without software write after reset");

  sw_write_a: assert property (
    @(posedge MCLK) disable iff (!RST_B)
    (!mif.in_reset && mif.sw_we) |=> (mode_r == $past(mif.sw_data)))
  else $error("software mode write not taken");
endmodule : mode_latch
`default_nettype wire

// [tb/osc_source.sv]
// Board clock source model for the oscillator input pin
`default_nettype none
module osc_source #(
  parameter int HALF_NS = 37
) (
  input wire logic run,
  input wire logic lvl,
  output logic osc
);
  timeunit 1ns;
  timeprecision 1ps;
  // Free running only when asked; otherwise a slow static level
  initial
  begin
    osc = 1'b0;
    forever
    begin
      #(HALF_NS);
      osc = run ? ~osc : lvl;
    end
  end
endmodule : osc_source
`default_nettype wire

// [tb/clock_mode_and_timer_pins_test.sv]
// Self-checking bench for the clock-mode and timer-pin block
`default_nettype none
module clock_mode_and_timer_pins_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic float_b = 1'b1;
  logic [clk_pins_pkg::MODE_W-1:0] straps = 3'h5;
  logic sw_we = 1'b0;
  logic [clk_pins_pkg::MODE_W-1:0] sw_data = 3'h0;
  logic int_osc_en = 1'b0;
  logic osc_lvl = 1'b0;
  logic tu0 = 1'b0;
  logic tu1 = 1'b0;
  logic host_en = 1'b0;
  logic host_req = 1'b0;
  wire logic osc;
  wire logic [clk_pins_pkg::MODE_W-1:0] mode;
  wire logic ext_lvl, xtal, mco, mco_oe, t0, t0_oe, t1, t1_oe;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #10 mclk = ~mclk;

  osc_source u_osc (.run(1'b0), .lvl(osc_lvl), .osc(osc));

  clock_mode_and_timer_pins u_dut (
    .MCLK(mclk), .RST_B(rst_b), .OUTPUT_FLOAT_B(float_b),
    .CLOCK_MODE_SEL_A(straps[0]), .CLOCK_MODE_SEL_B(straps[1]),
    .CLOCK_MODE_SEL_C(straps[2]), .SW_MODE_WE(sw_we),
    .SW_MODE_DATA(sw_data), .CLOCK_MODE(mode), .OSC_IN_EXT_CLOCK(osc),
    .INT_OSC_EN(int_osc_en), .EXT_CLOCK_LEVEL(ext_lvl),
    .CRYSTAL_DRIVE_OUT(xtal), .MACHINE_CLOCK_OUT(mco),
    .MACHINE_CLOCK_OUT_OE(mco_oe), .TIMER0_UNDERFLOW(tu0),
    .TIMER1_UNDERFLOW(tu1), .HOST_PORT_EN(host_en),
    .HOST_INTERRUPT_REQ(host_req), .TIMER0_PULSE_OUT(t0),
    .TIMER0_PULSE_OUT_OE(t0_oe), .TIMER1_PULSE_OUT(t1),
    .TIMER1_PULSE_OUT_OE(t1_oe)
  );

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // Second reset with new straps; earlier software value must be lost
  task automatic t_modes;
    @(posedge mclk);
    straps <= 3'h3;
    sw_we <= 1'b1;
    sw_data <= 3'h2;
    @(posedge mclk);
    sw_we <= 1'b0;
    @(negedge mclk);
    check("sw mode", 8'(mode), 8'h02);
    cyc(4);
    @(negedge mclk);
    check("straps ignored", 8'(mode), 8'h02);
    @(posedge mclk);
    rst_b <= 1'b0;
    cyc(3);
    rst_b <= 1'b1;
    cyc(3);
    @(negedge mclk);
    check("strap mode", 8'(mode), 8'h03);
  endtask : t_modes

  task automatic t_mclk;
    logic v;
    @(negedge mclk);
    v = mco;
    // Invert first: inside a size cast the operator would work on 8 bits
    repeat (4)
    begin
      @(negedge mclk);
      v = ~v;
      check("machine clock", 8'(mco), 8'(v));
    end
  endtask : t_mclk

  // Outputs must float a moment after the pin moves, not at an edge
  task automatic t_float;
    @(posedge mclk);
    float_b <= 1'b0;
    #1;
    check("oe", {5'h0, mco_oe, t0_oe, t1_oe}, 8'h00);
    @(posedge mclk);
    float_b <= 1'b1;
    #1;
    check("oe", {5'h0, mco_oe, t0_oe, t1_oe}, 8'h07);
  endtask : t_float

  task automatic t_osc;
    @(posedge mclk);
    osc_lvl <= 1'b1;
    cyc(6);
    check("ext level", 8'(ext_lvl), 8'h01);
    check("xtal idle", 8'(xtal), 8'h00);
    osc_lvl <= 1'b0;
    cyc(6);
    check("ext level", 8'(ext_lvl), 8'h00);
    int_osc_en <= 1'b1;
    float_b <= 1'b0;
    cyc(6);
    check("xtal while floating", 8'(xtal), 8'h01);
    float_b <= 1'b1;
  endtask : t_osc

  task automatic t_pulse(input bit sel, input logic [7:0] exp_n);
    int n;
    n = 0;
    @(posedge mclk);
    if (sel)
      tu1 <= 1'b1;
    else
      tu0 <= 1'b1;
    @(posedge mclk);
    tu0 <= 1'b0;
    tu1 <= 1'b0;
    repeat (8)
    begin
      @(negedge mclk);
      if ((sel ? t1 : t0) === 1'b1)
        n++;
    end
    check("pulse width", 8'(n), exp_n);
  endtask : t_pulse

  initial
  begin
    cyc(1);
    #1;
    check("reset mode", 8'(mode), 8'h07);
    cyc(1);
    rst_b <= 1'b1;
    cyc(3);
    @(negedge mclk);
    check("strap mode", 8'(mode), 8'h05);
    t_modes();
    t_mclk();
    t_float();
    t_osc();
    t_pulse(1'b0, 8'h02);
    t_pulse(1'b1, 8'h02);
    @(posedge mclk);
    host_en <= 1'b1;
    t_pulse(1'b1, 8'h00);
    @(posedge mclk);
    host_req <= 1'b1;
    cyc(1);
    #1;
    check("host interrupt", 8'(t1), 8'h01);
    summarize();
  end
endmodule : clock_mode_and_timer_pins_test
`default_nettype wire
